/* verilog/awt_ctrl.sv */
// Asynchronous memory port with extended-wait time-out handling.
// Assumes requests and wait input synchronous to ref_clk_i; one request
// is accepted when idle, and the SDRAM and register reads answer at once.
// Summary of operation
// - Time-out check only for chip selects configured for extended wait.
// - Wait held beyond the programmed limit during a read flags time-out.
// - A timed-out read returns an all-zero data word.
// - Register reads after a time-out return right data yet keep the error.
// - Error holds until a clean asynchronous access or any SDRAM access.
`timescale 1ns/1ps
`default_nettype none
module awt_ctrl
	import awt_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire awt_req_type req_i,
	output logic ready_o,
	output awt_rsp_type rsp_o,
	input wire logic [AWT_CS_N-1:0] ew_enable_i,
	input wire logic [AWT_LIMIT_W-1:0] ew_limit_i,
	input wire logic [AWT_DATA_W-1:0] reg_rdata_i,
	input wire logic [AWT_DATA_W-1:0] mem_rdata_i,
	input wire logic mem_wait_i,
	output logic [AWT_CS_N-1:0] mem_cs_o,
	output logic mem_oe_o,
	output logic mem_we_o,
	output logic [AWT_ADDR_W-1:0] mem_addr_o,
	output logic timeout_o
);

	typedef enum logic [1:0] {
		AWT_IDLE,
		AWT_STROBE,
		AWT_WAIT
	} awt_phase_type;

	typedef struct packed {
		awt_phase_type phase;
		logic write;
		logic ew;
		logic [AWT_CS_W-1:0] cs;
		logic [AWT_ADDR_W-1:0] addr;
		logic [AWT_STROBE_W-1:0] strobe_cnt;
		logic err;
		awt_rsp_type rsp;
	} awt_state_type;

	awt_state_type state;
	awt_state_type next_state;
	logic expired;
	logic cnt_clear;
	logic cnt_run;

	// Counting only on extended-wait reads; writes are not policed
	assign cnt_run = (state.phase == AWT_WAIT) && state.ew && !state.write
		&& mem_wait_i;
	assign cnt_clear = (state.phase != AWT_WAIT);

	awt_wait_counter u_cnt (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.clear_i(cnt_clear),
		.count_i(cnt_run),
		.limit_i(ew_limit_i),
		.expired_o(expired)
	);

	always_comb begin
		next_state = state;
		next_state.rsp.valid = 1'b0;
		case (state.phase)
			AWT_IDLE: begin
				if (req_i.valid) begin
					case (req_i.kind)
						AWT_ACC_ASYNC: begin
							next_state.phase = AWT_STROBE;
							next_state.write = req_i.write;
							next_state.cs = req_i.cs;
							next_state.addr = req_i.addr;
							next_state.ew = ew_enable_i[req_i.cs];
							next_state.strobe_cnt = AWT_STROBE_CYCLES;
						end
						AWT_ACC_SDRAM: begin
							// Any SDRAM access drops a held error
							next_state.err = 1'b0;
							next_state.rsp = '{valid: 1'b1, error: 1'b0,
								data: AWT_ZERO_DATA};
						end
						AWT_ACC_REGS: begin
							// Data is right, but the stale error rides along
							next_state.rsp = '{valid: 1'b1, error: state.err,
								data: reg_rdata_i};
						end
						default: begin
							next_state.rsp = '{valid: 1'b1, error: state.err,
								data: AWT_ZERO_DATA};
						end
					endcase
				end
			end
			AWT_STROBE: begin
				next_state.strobe_cnt = state.strobe_cnt - AWT_STROBE_ONE;
				if (state.strobe_cnt == AWT_STROBE_ONE) begin
					next_state.phase = AWT_WAIT;
				end
			end
			AWT_WAIT: begin
				if (expired) begin
					next_state.phase = AWT_IDLE;
					next_state.err = 1'b1;
					next_state.rsp = '{valid: 1'b1, error: 1'b1,
						data: AWT_ZERO_DATA};
				end else if (!mem_wait_i || !state.ew) begin
					// Clean completion: covers the non-ew select workarounds
					next_state.phase = AWT_IDLE;
					next_state.err = 1'b0;
					next_state.rsp = '{valid: 1'b1, error: 1'b0,
						data: state.write ? AWT_ZERO_DATA : mem_rdata_i};
				end
			end
			default: begin
				next_state.phase = AWT_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state <= '{phase: AWT_IDLE, write: 1'b0, ew: 1'b0,
				cs: '0, addr: '0, strobe_cnt: '0, err: 1'b0,
				rsp: '{valid: 1'b0, error: 1'b0, data: AWT_ZERO_DATA}};
		end else begin
			state <= next_state;
		end
	end

	// Only one access in flight: no queue, so the requester is stalled
	assign ready_o = (state.phase == AWT_IDLE);
	assign rsp_o = state.rsp;
	assign timeout_o = state.err;
	assign mem_addr_o = state.addr;
	assign mem_oe_o = (state.phase != AWT_IDLE) && !state.write;
	assign mem_we_o = (state.phase != AWT_IDLE) && state.write;

	genvar g;
	generate
		for (g = 0; g < AWT_CS_N; g++) begin : g_cs
			assign mem_cs_o[g] = (state.phase != AWT_IDLE)
				&& (state.cs == AWT_CS_W'(g));
		end
	endgenerate

	// Steps of one access, shared by the checks below
	sequence s_take_async;
		ready_o && req_i.valid && req_i.kind == AWT_ACC_ASYNC;
	endsequence

	sequence s_strobe_run;
		state.phase == AWT_STROBE ##1 state.phase == AWT_STROBE
		##1 state.phase == AWT_WAIT;
	endsequence

	sequence s_timeout_done;
		state.phase == AWT_WAIT && expired;
	endsequence

	sequence s_clean_done;
		state.phase == AWT_WAIT && !expired && (!mem_wait_i || !state.ew);
	endsequence

	sequence s_take_sdram;
		ready_o && req_i.valid && req_i.kind == AWT_ACC_SDRAM;
	endsequence

	sequence s_take_regs;
		ready_o && req_i.valid && req_i.kind == AWT_ACC_REGS;
	endsequence

	timeout_zero_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		s_timeout_done |=> rsp_o.valid && rsp_o.error
		&& rsp_o.data == AWT_ZERO_DATA)
		else $error("timed-out read not zero with error");

	timeout_flag_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		s_timeout_done |=> timeout_o)
		else $error("time-out not flagged");

	// Reaches through the counter, so a stray count shows up here
	no_ew_check_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		s_timeout_done |-> state.ew && !state.write)
		else $error("time-out on an access without extended wait");

	err_rise_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(timeout_o) |-> $past(expired)
		&& $past(state.phase) == AWT_WAIT)
		else $error("error raised without a wait time-out");

	reg_keep_err_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		s_take_regs |=> rsp_o.valid && rsp_o.error == $past(timeout_o)
		&& rsp_o.data == $past(reg_rdata_i))
		else $error("register read lost data or error");

	err_hold_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		timeout_o && !(ready_o && req_i.valid && req_i.kind == AWT_ACC_SDRAM)
		&& state.phase != AWT_WAIT |=> timeout_o)
		else $error("error dropped without clearing access");

	sdram_clear_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		s_take_sdram |=> !timeout_o && rsp_o.valid)
		else $error("SDRAM access did not clear error");

	clean_clear_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		s_clean_done |=> !timeout_o && !rsp_o.error)
		else $error("clean async access kept error");

	clean_data_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		s_clean_done ##0 !state.write |=> rsp_o.data == $past(mem_rdata_i))
		else $error("clean read lost the memory data");

	strobe_len_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		s_take_async |=> s_strobe_run)
		else $error("strobe phase length wrong");

endmodule // awt_ctrl
`default_nettype wire

/* shared/awt_pkg.sv */
// Package for the asynchronous wait time-out controller.
// Assumes a single 40 MHz system clock and synchronous active-high reset.
package awt_pkg;

	localparam int AWT_DATA_W = 32;
	localparam int AWT_ADDR_W = 24;
	localparam int AWT_CS_N = 4;
	localparam int AWT_CS_W = 2;
	localparam int AWT_LIMIT_W = 8;
	localparam int AWT_STROBE_W = 4;
	localparam logic [AWT_DATA_W-1:0] AWT_ZERO_DATA = 32'h0000_0000;
	localparam logic [AWT_LIMIT_W-1:0] AWT_CNT_RESET = 8'h00;
	localparam logic [AWT_LIMIT_W-1:0] AWT_CNT_ONE = 8'h01;
	localparam logic [AWT_STROBE_W-1:0] AWT_STROBE_CYCLES = 4'h2;
	localparam logic [AWT_STROBE_W-1:0] AWT_STROBE_ONE = 4'h1;

	// Kind of access taken from the on-chip bus
	typedef enum logic [1:0] {
		AWT_ACC_ASYNC,
		AWT_ACC_SDRAM,
		AWT_ACC_REGS
	} awt_acc_type;

	typedef struct packed {
		logic valid;
		logic write;
		awt_acc_type kind;
		logic [AWT_CS_W-1:0] cs;
		logic [AWT_ADDR_W-1:0] addr;
	} awt_req_type;

	typedef struct packed {
		logic valid;
		logic error;
		logic [AWT_DATA_W-1:0] data;
	} awt_rsp_type;

endpackage

/* verilog/awt_wait_counter.sv */
// Wait-cycle counter of the asynchronous memory port.
// Assumes the wait input is already synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module awt_wait_counter
	import awt_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic count_i,
	input wire logic [AWT_LIMIT_W-1:0] limit_i,
	output logic expired_o
);

	typedef struct packed {
		logic [AWT_LIMIT_W-1:0] cnt;
		logic expired;
	} awt_cnt_state_type;

	awt_cnt_state_type state;
	awt_cnt_state_type next_state;

	always_comb begin
		next_state = state;
		if (clear_i) begin
			next_state.cnt = AWT_CNT_RESET;
			next_state.expired = 1'b0;
		end else if (count_i && !state.expired) begin
			// Expire once wait stays active beyond the limit
			if (state.cnt >= limit_i) begin
				next_state.expired = 1'b1;
			end else begin
				next_state.cnt = state.cnt + AWT_CNT_ONE;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state <= '{cnt: AWT_CNT_RESET, expired: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign expired_o = state.expired;

	cnt_bound_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		!clear_i && count_i && !state.expired && state.cnt >= limit_i
		|=> expired_o)
		else $error("wait count passed limit without expiry");

endmodule // awt_wait_counter
`default_nettype wire

/* testbench/awt_mem_model.sv */
// Async memory model: drives wait and read data.
// Assumes one clock; selected means any chip select high.
`timescale 1ns/1ps
`default_nettype none
module awt_mem_model
	import awt_pkg::*;
#(
	parameter logic [AWT_DATA_W-1:0] DATA = 32'hC0DE_5A00,
	parameter int SLOW = 3
)
(
	input wire logic ref_clk_i,
	input wire logic [AWT_CS_N-1:0] mem_cs_i,
	input wire logic stuck_i,
	output logic [AWT_DATA_W-1:0] rdata_o,
	output logic wait_o
);
	logic tick = 1'b0;
	logic sel;
	int cnt = 0;
	assign sel = |mem_cs_i;
	always @(posedge ref_clk_i) begin
		tick <= ~tick;
		cnt <= sel ? cnt + 1 : 0;
	end
	// Unselected lines toggle so stale values never pass
	assign wait_o = sel ? (stuck_i || cnt < SLOW) : tick;
	assign rdata_o = sel ? DATA : {AWT_DATA_W{tick}};
endmodule // awt_mem_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench of the wait time-out controller.
// Assumes the memory model answers on any selected chip select.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import awt_pkg::*;
;
	localparam logic [31:0] MEMV = 32'hC0DE_5A00;
	localparam logic [31:0] REGV = 32'h1234_5678;
	localparam logic [31:0] REGV2 = 32'hA5A5_0F0F;
	localparam logic [7:0] LIM = 8'h05;
	localparam logic [7:0] LIM2 = 8'h02;
	localparam logic [23:0] ADDR = 24'h000040;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	awt_req_type req = '0;
	logic [3:0] ew = 4'h1;
	logic [7:0] lim = LIM;
	logic [31:0] regv = REGV;
	logic stuck = 1'b0;
	logic ready;
	awt_rsp_type rsp;
	logic [3:0] cs;
	logic oe;
	logic we;
	logic [23:0] addr;
	// Bus view in the first cycle after the take
	logic [3:0] s_cs;
	logic s_oe;
	logic s_we;
	logic [23:0] s_addr;
	logic [31:0] rdata;
	logic wt;
	logic tout;
	int fails = 0;
	int n_tests = 0;
	awt_rsp_type r;
	int n;

	always #12.5 ref_clk_i = ~ref_clk_i;

	awt_ctrl uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req),
		.ready_o(ready), .rsp_o(rsp), .ew_enable_i(ew), .ew_limit_i(lim),
		.reg_rdata_i(regv), .mem_rdata_i(rdata), .mem_wait_i(wt),
		.mem_cs_o(cs), .mem_oe_o(oe), .mem_we_o(we), .mem_addr_o(addr),
		.timeout_o(tout));
	awt_mem_model #(.DATA(MEMV), .SLOW(3)) mem (.ref_clk_i(ref_clk_i),
		.mem_cs_i(cs), .stuck_i(stuck), .rdata_o(rdata), .wait_o(wt));

	task automatic close_out;
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One access; latency counted from the take edge, bounded
	task automatic rd(input awt_acc_type k, input logic [1:0] c,
		input logic w);
		n = 0;
		@(posedge ref_clk_i) req <= '{1'b1, w, k, c, ADDR};
		@(posedge ref_clk_i) req.valid <= 1'b0;
		do begin
			@(posedge ref_clk_i);
			n++;
			if (n == 1) begin
				s_cs = cs;
				s_oe = oe;
				s_we = we;
				s_addr = addr;
			end
		end while (rsp.valid !== 1'b1 && n < 64);
		r = rsp;
		chk(32'(n < 64), 32'h1);
		// Let the flag settle past the completion edge
		@(posedge ref_clk_i);
	endtask

	task automatic t_clean;
		rd(AWT_ACC_ASYNC, 2'h0, 1'b0);
		chk(r.data, MEMV);
		chk(32'(r.error), 32'h0);
		chk(32'(s_cs), 32'h1);
		chk(32'({s_oe, s_we}), 32'h2);
		chk(32'(s_addr), 32'(ADDR));
	endtask

	// Writes on an extended-wait select finish on wait low and are never timed out
	task automatic t_write;
		rd(AWT_ACC_ASYNC, 2'h0, 1'b1);
		chk(32'(r.error), 32'h0);
		chk(32'(tout), 32'h0);
		chk(32'({s_oe, s_we}), 32'h1);
	endtask

	task automatic t_timeout;
		@(posedge ref_clk_i) stuck <= 1'b1;
		rd(AWT_ACC_ASYNC, 2'h0, 1'b0);
		chk(32'(r.error), 32'h1);
		chk(r.data, AWT_ZERO_DATA);
		chk(32'(tout), 32'h1);
		chk(32'(s_cs), 32'h1);
		// Strobe, then limit plus one counting cycles, then the answer
		chk(32'(n), 32'(int'(AWT_STROBE_CYCLES) + int'(lim) + 3));
	endtask

	task automatic t_regs;
		rd(AWT_ACC_REGS, 2'h0, 1'b0);
		chk(r.data, REGV);
		chk(32'(r.error), 32'h1);
		@(posedge ref_clk_i) regv <= REGV2;
		rd(AWT_ACC_REGS, 2'h0, 1'b0);
		chk(r.data, REGV2);
		chk(32'(r.error), 32'h1);
		chk(32'(s_cs), 32'h0);
		chk(32'(tout), 32'h1);
	endtask

	// Wait held high, yet a select without extended wait ignores it
	task automatic t_clr_other;
		rd(AWT_ACC_ASYNC, 2'h1, 1'b0);
		chk(32'(r.error), 32'h0);
		chk(r.data, MEMV);
		chk(32'(tout), 32'h0);
		chk(32'(s_cs), 32'h2);
		chk(32'(n), 32'(int'(AWT_STROBE_CYCLES) + 2));
	endtask

	task automatic t_clr_sdram;
		@(posedge ref_clk_i) lim <= LIM2;
		t_timeout();
		rd(AWT_ACC_SDRAM, 2'h0, 1'b0);
		chk(32'(r.error), 32'h0);
		chk(32'(tout), 32'h0);
	endtask

	task automatic t_clr_disable;
		t_timeout();
		@(posedge ref_clk_i) ew <= 4'h0;
		rd(AWT_ACC_ASYNC, 2'h0, 1'b0);
		chk(32'(r.error), 32'h0);
		chk(r.data, MEMV);
		chk(32'(tout), 32'h0);
	endtask

	initial begin
		repeat (3000) @(posedge ref_clk_i);
		fails++;
		close_out();
	end

	initial begin
		repeat (16) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		chk(32'(ready), 32'h1);
		chk(32'(tout), 32'h0);
		t_clean();
		t_write();
		t_timeout();
		t_regs();
		t_clr_other();
		t_clr_sdram();
		t_clr_disable();
		close_out();
	end
endmodule // testbench
`default_nettype wire
